// ==== acms_pkg.sv ====
// package: register map, bit positions and timing for the axis status block
package acms_pkg;
	localparam int ACMS_WORD_W = 16;
	localparam int ACMS_ADDR_W = 12;
	// register indices; byte address is four times the index
	localparam int ACMS_CMD_IDX = 2;
	localparam int ACMS_MOT_IDX = 3;
	localparam int ACMS_CTRL_IDX = 8;
	localparam logic [11:0] ACMS_CMD_ADDR = 12'(ACMS_CMD_IDX * 4);
	localparam logic [11:0] ACMS_MOT_ADDR = 12'(ACMS_MOT_IDX * 4);
	localparam logic [11:0] ACMS_CTRL_ADDR = 12'(ACMS_CTRL_IDX * 4);
	// command status word bits
	localparam int ACMS_C_BUSY = 0;
	localparam int ACMS_C_STOPIN = 4;
	localparam int ACMS_C_GRPSTOP = 5;
	localparam int ACMS_C_ALLSTOP = 6;
	localparam int ACMS_C_HSPTP = 7;
	localparam int ACMS_C_STARTINV = 8;
	localparam int ACMS_C_DEVRST = 9;
	localparam int ACMS_C_STOPEXE = 12;
	localparam int ACMS_C_OPDONE = 13;
	// motion status word bits
	localparam int ACMS_M_UNLOCK = 0;
	localparam int ACMS_M_LOCKED = 1;
	localparam int ACMS_M_ACCEL = 3;
	localparam int ACMS_M_CONST = 4;
	localparam int ACMS_M_DECEL = 5;
	localparam int ACMS_M_PASS = 6;
	localparam int ACMS_M_WAITC = 7;
	localparam int ACMS_M_DSTOP = 8;
	localparam int ACMS_M_ISTOP = 9;
	localparam int ACMS_M_SYNCW = 10;
	// implemented bits of each word; the rest read zero
	localparam logic [15:0] ACMS_CMD_MASK = 16'h33f1;
	localparam logic [15:0] ACMS_MOT_MASK = 16'h07fb;
	// control register fields and reset
	localparam int ACMS_K_ASSIGNED = 0;
	localparam int ACMS_K_EVCLR = 1;
	localparam logic [15:0] ACMS_CTRL_RST = 16'h0001;
	localparam logic [15:0] ACMS_CTRL_WMASK = 16'h0001;
	localparam logic [15:0] ACMS_ZERO16 = 16'h0000;
	// timing
	localparam int ACMS_CLK_NS = 50;
	localparam int ACMS_DEVRST_ACK_NS = 10000;
	localparam int ACMS_DEVRST_CYC = (ACMS_DEVRST_ACK_NS + ACMS_CLK_NS - 1) / ACMS_CLK_NS;
	typedef enum logic [1:0] {ACMS_DR_IDLE, ACMS_DR_WAIT} acms_dr_state_t;
	// one-hot word with a single bit at pos
	function automatic logic [15:0] acms_bit(input int pos);
		acms_bit = 16'h0001 << pos;
	endfunction
endpackage

// ==== acms_flags_if.sv ====
// interface: status carried from the sub-blocks to the top
`timescale 1ns/1ps
`default_nettype none
interface acms_flags_if;
	logic [15:0] mot_word;
	logic devrst_timeout;
	modport mot (output mot_word);
	modport dev (output devrst_timeout);
	modport top (input mot_word, input devrst_timeout);
endinterface
`default_nettype wire

// ==== acms_motion_status.sv ====
// motion status word: servo, profile phase and stop-in-progress flags
`timescale 1ns/1ps
`default_nettype none
module acms_motion_status
	import acms_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic servo_locked,
	input wire logic axis_moving,
	input wire logic axis_operating,
	input wire logic prof_accel,
	input wire logic prof_const,
	input wire logic prof_decel,
	input wire logic pass_phase,
	input wire logic wait_complete,
	input wire logic decel_stop_req,
	input wire logic imm_stop_req,
	input wire logic cam_active,
	input wire logic link_cond_met,
	acms_flags_if.mot flags
);
	logic dstop_reg;
	logic istop_reg;

	// deceleration stop in progress until rest, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dstop_reg <= 1'b0;
		end else if (decel_stop_req && axis_operating) begin
			dstop_reg <= 1'b1; // [RULE15]
		end else if (!axis_moving) begin
			dstop_reg <= 1'b0; // [RULE15]
		end
	end

	// immediate stop in progress until rest, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istop_reg <= 1'b0;
		end else if (imm_stop_req && axis_operating) begin
			istop_reg <= 1'b1; // [RULE16]
		end else if (!axis_moving) begin
			istop_reg <= 1'b0; // [RULE16]
		end
	end

	// assemble the word; unused positions stay zero
	always_comb begin
		flags.mot_word = ACMS_ZERO16;
		if (!servo_locked) flags.mot_word |= acms_bit(ACMS_M_UNLOCK); // [RULE10]
		if (servo_locked && !axis_moving) flags.mot_word |= acms_bit(ACMS_M_LOCKED); // [RULE11]
		if (prof_accel) flags.mot_word |= acms_bit(ACMS_M_ACCEL); // [RULE12]
		if (prof_const) flags.mot_word |= acms_bit(ACMS_M_CONST); // [RULE12]
		if (prof_decel) flags.mot_word |= acms_bit(ACMS_M_DECEL); // [RULE12]
		if (pass_phase) flags.mot_word |= acms_bit(ACMS_M_PASS); // [RULE13]
		if (wait_complete) flags.mot_word |= acms_bit(ACMS_M_WAITC); // [RULE14]
		if (dstop_reg) flags.mot_word |= acms_bit(ACMS_M_DSTOP);
		if (istop_reg) flags.mot_word |= acms_bit(ACMS_M_ISTOP);
		if (cam_active && !link_cond_met) flags.mot_word |= acms_bit(ACMS_M_SYNCW); // [RULE17]
		flags.mot_word &= ACMS_MOT_MASK; // [RULE19]
	end
endmodule
`default_nettype wire

// ==== acms_devrst_watch.sv ====
// watchdog for an unanswered deviation counter reset during origin search
`timescale 1ns/1ps
`default_nettype none
module acms_devrst_watch
	import acms_pkg::*;
#(
	parameter int ACK_CYC = ACMS_DEVRST_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic origin_search,
	input wire logic devrst_out,
	input wire logic devrst_ack,
	acms_flags_if.dev flags
);
	acms_dr_state_t state_reg;
	logic [15:0] cnt_reg;
	logic timeout_reg;

	// wait for the answer after each reset pulse issued in origin search
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ACMS_DR_IDLE;
			cnt_reg <= ACMS_ZERO16;
			timeout_reg <= 1'b0;
		end else begin
			timeout_reg <= 1'b0;
			case (state_reg)
				ACMS_DR_IDLE: begin
					cnt_reg <= ACMS_ZERO16;
					if (origin_search && devrst_out) state_reg <= ACMS_DR_WAIT;
				end
				ACMS_DR_WAIT: begin
					if (devrst_ack || !origin_search) begin
						state_reg <= ACMS_DR_IDLE;
					end else if (cnt_reg == 16'(ACK_CYC - 1)) begin
						timeout_reg <= 1'b1; // [RULE7]
						state_reg <= ACMS_DR_IDLE;
					end else begin
						cnt_reg <= cnt_reg + 16'h0001;
					end
				end
				default: state_reg <= ACMS_DR_IDLE;
			endcase
		end
	end

	assign flags.devrst_timeout = timeout_reg;
endmodule
`default_nettype wire

// ==== acms_top.sv ====
// top: APB slave with the axis command and motion status words
//
// Functional notes
// RULE1: stop commands or stop pins set stop-input flag
// RULE2: no start accepted while stop-input flag set
// RULE3: group stop flag on accepted stop or request
// RULE4: all-units stop flag likewise for all units
// RULE5: flag acknowledges high-speed point start
// RULE6: start-rejected flag on failed start conditions
// RULE7: flag unanswered deviation counter reset in search
// RULE8: stop-executed flag on halts in manual/direct
// RULE9: operation-completed flag on direct finish or jog stop
// RULE10: servo-released bit while servo unlocked
// RULE11: servo-held bit while stopped and locked
// RULE12: accel, constant, decel phase bits
// RULE13: pass bit during continuous pattern transitions
// RULE14: completion-waiting bit while awaiting positioning done
// RULE15: decel-stop bit from request until rest
// RULE16: immediate-stop bit from request until rest
// RULE17: cam sync-condition waiting bit until link established
// RULE18: busy bit while operating or unassigned memory axis
// RULE19: unused bit positions read zero
// RULE20: both words update together on one edge
`timescale 1ns/1ps
`default_nettype none
module acms_top
	import acms_pkg::*;
#(
	parameter int DEVRST_ACK_CYC = ACMS_DEVRST_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic emg_stop_pin,
	input wire logic decel_pin,
	input wire logic imm_stop_cmd,
	input wire logic dec_stop_cmd,
	input wire logic start_cmd,
	output logic start_grant,
	output logic start_refused,
	input wire logic hs_ptp_start,
	input wire logic start_cond_fail,
	input wire logic start_prio_fail,
	input wire logic grp_stop_req,
	input wire logic all_stop_req,
	input wire logic sys_stopped,
	input wire logic origin_search,
	input wire logic devrst_out,
	input wire logic devrst_ack,
	input wire logic manual_or_direct,
	input wire logic direct_op,
	input wire logic halt_decel,
	input wire logic halt_devrst,
	input wire logic halt_unlock,
	input wire logic halt_error,
	input wire logic pos_done,
	input wire logic jog_stopped,
	input wire logic axis_operating,
	input wire logic memory_op,
	input wire logic servo_locked,
	input wire logic axis_moving,
	input wire logic prof_accel,
	input wire logic prof_const,
	input wire logic prof_decel,
	input wire logic pass_phase,
	input wire logic wait_complete,
	input wire logic decel_stop_req,
	input wire logic imm_stop_req,
	input wire logic cam_active,
	input wire logic link_cond_met
);
	acms_flags_if flags ();

	// pin synchronisers
	logic emg_meta_reg;
	logic emg_sync_reg;
	logic decin_meta_reg;
	logic decin_sync_reg;

	// control and sticky flags
	logic [15:0] ctrl_reg;
	logic stop_in_reg;
	logic grp_latch_reg;
	logic all_latch_reg;
	logic hsptp_reg;
	logic startinv_reg;
	logic devrst_reg;
	logic stopexe_reg;
	logic opdone_reg;

	// published words
	logic [15:0] cmd_word_reg;
	logic [15:0] mot_word_reg;
	logic [15:0] cmd_word_next;

	// bus outputs
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic start_grant_reg;
	logic start_refused_reg;

	// derived strobes
	logic setup_phase;
	logic access_done;
	logic addr_hit;
	logic ctrl_write;
	logic ev_clear;
	logic stop_source;
	logic start_ok;

	acms_motion_status u_motion (
		.pclk(pclk),
		.presetn(presetn),
		.servo_locked(servo_locked),
		.axis_moving(axis_moving),
		.axis_operating(axis_operating),
		.prof_accel(prof_accel),
		.prof_const(prof_const),
		.prof_decel(prof_decel),
		.pass_phase(pass_phase),
		.wait_complete(wait_complete),
		.decel_stop_req(decel_stop_req),
		.imm_stop_req(imm_stop_req),
		.cam_active(cam_active),
		.link_cond_met(link_cond_met),
		.flags(flags.mot)
	);

	acms_devrst_watch #(
		.ACK_CYC(DEVRST_ACK_CYC)
	) u_devrst (
		.pclk(pclk),
		.presetn(presetn),
		.origin_search(origin_search),
		.devrst_out(devrst_out),
		.devrst_ack(devrst_ack),
		.flags(flags.dev)
	);

	// two-stage sync of the emergency and deceleration pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			emg_meta_reg <= 1'b0;
			emg_sync_reg <= 1'b0;
			decin_meta_reg <= 1'b0;
			decin_sync_reg <= 1'b0;
		end else begin
			emg_meta_reg <= emg_stop_pin;
			emg_sync_reg <= emg_meta_reg;
			decin_meta_reg <= decel_pin;
			decin_sync_reg <= decin_meta_reg;
		end
	end

	// bus phase decode
	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready_reg;
	assign addr_hit = (paddr == ACMS_CMD_ADDR) || (paddr == ACMS_MOT_ADDR)
		|| (paddr == ACMS_CTRL_ADDR);
	assign ctrl_write = access_done && pwrite && (paddr == ACMS_CTRL_ADDR);
	// a write of one to the clear field drops the event flags
	assign ev_clear = ctrl_write && pwdata[ACMS_K_EVCLR];

	// any stop cause currently present
	assign stop_source = imm_stop_cmd || dec_stop_cmd || emg_sync_reg || decin_sync_reg;
	// a start is taken only with no stop pending
	assign start_ok = !stop_in_reg && !stop_source; // [RULE2]

	// control register, write only on completed access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= ACMS_CTRL_RST;
		end else if (ctrl_write) begin
			ctrl_reg <= pwdata[15:0] & ACMS_CTRL_WMASK;
		end
	end

	// stop input flag: set by any stop cause, cleared once causes gone and at rest
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_in_reg <= 1'b0;
		end else if (stop_source) begin
			stop_in_reg <= 1'b1; // [RULE1]
		end else if (!axis_moving) begin
			stop_in_reg <= 1'b0;
		end
	end

	// start gating toward the profile generator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_grant_reg <= 1'b0;
			start_refused_reg <= 1'b0;
		end else begin
			start_grant_reg <= start_cmd && start_ok; // [RULE2]
			start_refused_reg <= start_cmd && !start_ok; // [RULE2]
		end
	end

	// group and all-units stop latches: accepted request with system stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grp_latch_reg <= 1'b0;
			all_latch_reg <= 1'b0;
		end else begin
			if (grp_stop_req && sys_stopped) begin
				grp_latch_reg <= 1'b1; // [RULE3]
			end else if (ev_clear || start_grant_reg) begin
				grp_latch_reg <= 1'b0;
			end
			if (all_stop_req && sys_stopped) begin
				all_latch_reg <= 1'b1; // [RULE4]
			end else if (ev_clear || start_grant_reg) begin
				all_latch_reg <= 1'b0;
			end
		end
	end

	// start related event flags; set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hsptp_reg <= 1'b0;
			startinv_reg <= 1'b0;
		end else begin
			if (hs_ptp_start) begin
				hsptp_reg <= 1'b1; // [RULE5]
			end else if (ev_clear) begin
				hsptp_reg <= 1'b0;
			end
			if (start_cond_fail || start_prio_fail) begin
				startinv_reg <= 1'b1; // [RULE6]
			end else if (ev_clear || start_grant_reg) begin
				startinv_reg <= 1'b0;
			end
		end
	end

	// deviation counter reset not answered during origin search
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			devrst_reg <= 1'b0;
		end else if (flags.devrst_timeout) begin
			devrst_reg <= 1'b1; // [RULE7]
		end else if (ev_clear || start_grant_reg) begin
			devrst_reg <= 1'b0;
		end
	end

	// stop executed and operation completed flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stopexe_reg <= 1'b0;
			opdone_reg <= 1'b0;
		end else begin
			if (manual_or_direct && (halt_decel || halt_devrst || halt_unlock || halt_error)) begin
				stopexe_reg <= 1'b1; // [RULE8]
			end else if (ev_clear || start_grant_reg) begin
				stopexe_reg <= 1'b0;
			end
			if (direct_op && (pos_done || jog_stopped)) begin
				opdone_reg <= 1'b1; // [RULE9]
			end else if (ev_clear || start_grant_reg) begin
				opdone_reg <= 1'b0;
			end
		end
	end

	// command word assembly
	always_comb begin
		cmd_word_next = ACMS_ZERO16;
		if (axis_operating || (memory_op && !ctrl_reg[ACMS_K_ASSIGNED])) begin
			cmd_word_next |= acms_bit(ACMS_C_BUSY); // [RULE18]
		end
		if (stop_in_reg) cmd_word_next |= acms_bit(ACMS_C_STOPIN); // [RULE1]
		if (grp_latch_reg || grp_stop_req) cmd_word_next |= acms_bit(ACMS_C_GRPSTOP); // [RULE3]
		if (all_latch_reg || all_stop_req) cmd_word_next |= acms_bit(ACMS_C_ALLSTOP); // [RULE4]
		if (hsptp_reg) cmd_word_next |= acms_bit(ACMS_C_HSPTP);
		if (startinv_reg) cmd_word_next |= acms_bit(ACMS_C_STARTINV);
		if (devrst_reg) cmd_word_next |= acms_bit(ACMS_C_DEVRST);
		if (stopexe_reg) cmd_word_next |= acms_bit(ACMS_C_STOPEXE);
		if (opdone_reg) cmd_word_next |= acms_bit(ACMS_C_OPDONE);
		cmd_word_next &= ACMS_CMD_MASK; // [RULE19]
	end

	// both words load on the same edge, held while a read is in flight
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_word_reg <= ACMS_ZERO16;
			mot_word_reg <= ACMS_ZERO16;
		end else if (!(psel && !pwrite)) begin
			cmd_word_reg <= cmd_word_next; // [RULE20]
			mot_word_reg <= flags.mot_word; // [RULE20]
		end
	end

	// apb answer: ready one cycle after setup, data and error with it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= setup_phase;
			if (setup_phase) begin
				// unmapped address, or write to a read-only word
				pslverr_reg <= !addr_hit || (pwrite && (paddr != ACMS_CTRL_ADDR));
				if (pwrite) begin
					prdata_reg <= 32'h0000_0000;
				end else if (paddr == ACMS_CMD_ADDR) begin
					prdata_reg <= {16'h0000, cmd_word_reg}; // [RULE19]
				end else if (paddr == ACMS_MOT_ADDR) begin
					prdata_reg <= {16'h0000, mot_word_reg}; // [RULE19]
				end else if (paddr == ACMS_CTRL_ADDR) begin
					prdata_reg <= {16'h0000, ctrl_reg};
				end else begin
					prdata_reg <= 32'h0000_0000;
				end
			end else begin
				pslverr_reg <= 1'b0;
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign start_grant = start_grant_reg;
	assign start_refused = start_refused_reg;
endmodule
`default_nettype wire

// ==== acms_top_assertions.sv ====
// checker: bus timing, unused bits and start answer of the status block
`timescale 1ns/1ps
`default_nettype none
module acms_top_assertions
	import acms_pkg::*;
#(
	parameter int DEVRST_ACK_CYC = ACMS_DEVRST_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic imm_stop_cmd,
	input wire logic dec_stop_cmd,
	input wire logic start_cmd,
	input wire logic start_grant,
	input wire logic start_refused
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// bus phases
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable && pready;
	endsequence
	// decoded register hit
	logic mapped;
	assign mapped = paddr == ACMS_CMD_ADDR || paddr == ACMS_MOT_ADDR || paddr == ACMS_CTRL_ADDR;
	ready_next_a: assert property (setup_s |=> access_s) else $error("pready missing");
	ready_only_a: assert property (pready |-> $past(psel && !penable))
		else $error("pready without setup");
	upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	cmd_unused_a: assert property ((setup_s and (!pwrite && paddr == ACMS_CMD_ADDR))
		|=> (prdata[15:0] & ~ACMS_CMD_MASK) == 16'h0000) else $error("command word spare bit");
	mot_unused_a: assert property ((setup_s and (!pwrite && paddr == ACMS_MOT_ADDR))
		|=> (prdata[15:0] & ~ACMS_MOT_MASK) == 16'h0000) else $error("motion word spare bit");
	unmapped_err_a: assert property ((setup_s and !mapped) |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	ro_write_a: assert property ((setup_s and (pwrite && paddr != ACMS_CTRL_ADDR))
		|=> pslverr) else $error("status word write not refused");
	start_one_a: assert property (start_cmd |=> start_grant != start_refused)
		else $error("start answer not exactly one");
	start_idle_a: assert property (!start_cmd |=> !start_grant && !start_refused)
		else $error("start answer without request");
	stop_refuse_a: assert property (start_cmd && (imm_stop_cmd || dec_stop_cmd)
		|=> start_refused) else $error("start granted during stop");
endmodule
bind acms_top acms_top_assertions #(.DEVRST_ACK_CYC(DEVRST_ACK_CYC)) u_chk (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .imm_stop_cmd,
	.dec_stop_cmd, .start_cmd, .start_grant, .start_refused);
`default_nettype wire

// ==== acms_host_model.sv ====
// host controller model: bus master that reads and writes the words
`timescale 1ns/1ps
`default_nettype none
module acms_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// setup, access until pready, then release with inverted leftovers
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ==== acms_top_tb.sv ====
// testbench: status words, start refusal and register access
`timescale 1ns/1ps
`default_nettype none
module acms_top_tb
	import acms_pkg::*;
;
	localparam int ACK_N = 5;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, start_grant, start_refused, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0] stp = 4'h0; // imm cmd, dec cmd, emg pin, decel pin
	logic [3:0] sp = 4'h0; // start, reset ack, decel req, imm req
	logic [11:0] ev = 12'h000; // event pulses
	logic [5:0] lv = 6'h0f; // mode and operation levels
	logic [8:0] mv = 9'h001; // servo and profile levels
	logic [8:0] m;
	int ebit[12] = '{7, 8, 8, 5, 6, 9, 12, 12, 12, 12, 13, 13};
	int fail_count = 0;
	int check_count = 0;
	// clock
	always #(ACMS_CLK_NS / 2) pclk = ~pclk;
	acms_top #(.DEVRST_ACK_CYC(ACK_N)) u_acms_top (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.imm_stop_cmd(stp[0]), .dec_stop_cmd(stp[1]), .emg_stop_pin(stp[2]), .decel_pin(stp[3]),
		.start_cmd(sp[0]), .start_grant(start_grant), .start_refused(start_refused),
		.hs_ptp_start(ev[0]), .start_cond_fail(ev[1]), .start_prio_fail(ev[2]),
		.grp_stop_req(ev[3]), .all_stop_req(ev[4]), .devrst_out(ev[5]), .halt_decel(ev[6]),
		.halt_devrst(ev[7]), .halt_unlock(ev[8]), .halt_error(ev[9]), .pos_done(ev[10]),
		.jog_stopped(ev[11]), .devrst_ack(sp[1]), .decel_stop_req(sp[2]), .imm_stop_req(sp[3]),
		.manual_or_direct(lv[0]), .direct_op(lv[1]), .sys_stopped(lv[2]),
		.origin_search(lv[3]), .axis_operating(lv[4]), .memory_op(lv[5]),
		.servo_locked(mv[0]), .axis_moving(mv[1]), .prof_accel(mv[2]), .prof_const(mv[3]),
		.prof_decel(mv[4]), .pass_phase(mv[5]), .wait_complete(mv[6]), .cam_active(mv[7]),
		.link_cond_met(mv[8]));
	acms_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	// expected motion word from the levels
	function automatic logic [31:0] mot_exp(input logic [8:0] v);
		mot_exp = 32'h0;
		mot_exp[ACMS_M_UNLOCK] = !v[0];
		mot_exp[ACMS_M_LOCKED] = v[0] && !v[1];
		mot_exp[ACMS_M_DECEL:ACMS_M_ACCEL] = v[4:2];
		mot_exp[ACMS_M_WAITC:ACMS_M_PASS] = v[6:5];
		mot_exp[ACMS_M_SYNCW] = v[7] && !v[8];
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		host.xfer(1'b0, a, 32'h0, rdat, rerr);
		check(rdat, exp);
	endtask
	task wr(input logic [31:0] d);
		host.xfer(1'b1, ACMS_CTRL_ADDR, d, rdat, rerr);
		cyc(4);
	endtask
	// one start pulse, answer looked at mid-cycle
	task strt(input logic [31:0] exp);
		sp[0] <= 1'b1;
		cyc(1);
		sp[0] <= 1'b0;
		@(negedge pclk);
		check({30'h0, start_grant, start_refused}, exp);
		cyc(1);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		cyc(20);
		presetn <= 1'b1;
		cyc(4);
		rd(ACMS_CTRL_ADDR, {16'h0, ACMS_CTRL_RST});
		rd(ACMS_CMD_ADDR, 32'h0);
		host.xfer(1'b0, 12'h010, 32'h0, rdat, rerr);
		check({rdat[30:0], rerr}, 32'h1);
		host.xfer(1'b1, ACMS_MOT_ADDR, 32'hffff, rdat, rerr);
		check({31'h0, rerr}, 32'h1);
		for (int i = 0; i < 10; i++) begin
			m = (i == 9) ? 9'h081 : 9'h001 ^ (9'h001 << i);
			mv <= m;
			cyc(4);
			rd(ACMS_MOT_ADDR, mot_exp(m));
		end
		lv[4] <= 1'b1;
		for (int i = 2; i < 4; i++) begin
			mv <= 9'h003;
			sp[i] <= 1'b1;
			cyc(1);
			sp[i] <= 1'b0;
			cyc(4);
			rd(ACMS_MOT_ADDR, 32'h0100 << (i - 2));
			rd(ACMS_CMD_ADDR, 32'h1);
			mv <= 9'h001;
			cyc(4);
			rd(ACMS_MOT_ADDR, 32'h2);
		end
		lv[4] <= 1'b0;
		wr(32'h0);
		lv[5] <= 1'b1;
		cyc(4);
		rd(ACMS_CMD_ADDR, 32'h1);
		lv[5] <= 1'b0;
		wr(32'h1);
		for (int i = 0; i < 4; i++) begin
			stp[i] <= 1'b1;
			cyc(6);
			rd(ACMS_CMD_ADDR, 32'h10);
			strt(32'h1);
			stp[i] <= 1'b0;
			cyc(6);
			wr(32'h3);
			rd(ACMS_CMD_ADDR, 32'h0);
			strt(32'h2);
		end
		for (int i = 0; i < 12; i++) begin
			ev[i] <= 1'b1;
			cyc(1);
			ev[i] <= 1'b0;
			cyc(ACK_N + 6);
			rd(ACMS_CMD_ADDR, 32'h1 << ebit[i]);
			wr(32'h3);
			rd(ACMS_CMD_ADDR, 32'h0);
		end
		ev[5] <= 1'b1;
		cyc(1);
		ev[5] <= 1'b0;
		sp[1] <= 1'b1;
		cyc(1);
		sp[1] <= 1'b0;
		cyc(ACK_N + 6);
		rd(ACMS_CMD_ADDR, 32'h0);
		wr(32'h0);
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		cyc(4);
		rd(ACMS_CTRL_ADDR, {16'h0, ACMS_CTRL_RST});
		summarize();
	end
	// watchdog against a hung transfer
	initial begin
		cyc(20000);
		fail_count++;
		summarize();
	end
endmodule
`default_nettype wire
